// *** rtl/ipeb_pkg.sv ***
package ipeb_pkg;

    localparam int unsigned IPEB_DATA_W    = 32;
    localparam int unsigned IPEB_ADDR_W    = 8;
    localparam int unsigned IPEB_GROUPS    = 8;

    // register byte offsets
    localparam logic [7:0] IPEB_OFS_ENABLE7 = 8'h00;
    localparam logic [7:0] IPEB_OFS_PRIO0   = 8'h04;
    localparam logic [7:0] IPEB_OFS_PRIO7   = 8'h20;
    localparam logic [7:0] IPEB_OFS_STATUS  = 8'h24;

    // implemented bits of the final enable register
    localparam logic [7:0] IPEB_ENABLE7_MASK  = 8'hE1;
    localparam logic [7:0] IPEB_ENABLE7_RESET = 8'h00;

    // implemented bits of each priority register, group 0 first
    localparam logic [7:0] IPEB_PRIO_MASK0 = 8'h37;
    localparam logic [7:0] IPEB_PRIO_MASK1 = 8'hC3;
    localparam logic [7:0] IPEB_PRIO_MASK2 = 8'hC3;
    localparam logic [7:0] IPEB_PRIO_MASK3 = 8'hFF;
    localparam logic [7:0] IPEB_PRIO_MASK4 = 8'h3F;
    localparam logic [7:0] IPEB_PRIO_MASK5 = 8'h07;
    localparam logic [7:0] IPEB_PRIO_MASK6 = 8'h03;
    localparam logic [7:0] IPEB_PRIO_MASK7 = 8'hE1;

    // status register field positions
    localparam int unsigned IPEB_STAT_HIGH_BIT = 0;
    localparam int unsigned IPEB_STAT_LOW_BIT  = 1;

    // field positions, final enable and eighth priority register
    localparam int unsigned IPEB_MEMSCAN_BIT   = 7;
    localparam int unsigned IPEB_CHECKSUM_BIT  = 6;
    localparam int unsigned IPEB_NONVOL_BIT    = 5;
    localparam int unsigned IPEB_WAVEFORM_BIT  = 0;

    // field positions, first priority register
    localparam int unsigned IPEB_TIMER_ZERO_BIT  = 5;
    localparam int unsigned IPEB_PIN_CHANGE_BIT  = 4;
    localparam int unsigned IPEB_EXT_TWO_BIT     = 2;
    localparam int unsigned IPEB_EXT_ONE_BIT     = 1;
    localparam int unsigned IPEB_EXT_ZERO_BIT    = 0;

    // field positions, second priority register
    localparam int unsigned IPEB_OSC_FAIL_BIT    = 7;
    localparam int unsigned IPEB_CLK_SWITCH_BIT  = 6;
    localparam int unsigned IPEB_CONV_THRESH_BIT = 1;
    localparam int unsigned IPEB_CONV_DONE_BIT   = 0;

    // field positions, third priority register
    localparam int unsigned IPEB_VOLT_DETECT_BIT = 7;
    localparam int unsigned IPEB_ZERO_CROSS_BIT  = 6;
    localparam int unsigned IPEB_COMP_TWO_BIT    = 1;
    localparam int unsigned IPEB_COMP_ONE_BIT    = 0;

    // field positions, fourth priority register
    localparam int unsigned IPEB_SER2_RX_BIT     = 7;
    localparam int unsigned IPEB_SER2_TX_BIT     = 6;
    localparam int unsigned IPEB_SER1_RX_BIT     = 5;
    localparam int unsigned IPEB_SER1_TX_BIT     = 4;
    localparam int unsigned IPEB_SYNC2_COLL_BIT  = 3;
    localparam int unsigned IPEB_SYNC2_EVT_BIT   = 2;
    localparam int unsigned IPEB_SYNC1_COLL_BIT  = 1;
    localparam int unsigned IPEB_SYNC1_EVT_BIT   = 0;

    // field positions, fifth priority register
    localparam int unsigned IPEB_TIMER6_BIT      = 5;
    localparam int unsigned IPEB_TIMER5_BIT      = 4;
    localparam int unsigned IPEB_TIMER4_BIT      = 3;
    localparam int unsigned IPEB_TIMER3_BIT      = 2;
    localparam int unsigned IPEB_TIMER2_BIT      = 1;
    localparam int unsigned IPEB_TIMER1_BIT      = 0;

    // field positions, sixth and seventh priority registers
    localparam int unsigned IPEB_GATE5_BIT       = 2;
    localparam int unsigned IPEB_GATE3_BIT       = 1;
    localparam int unsigned IPEB_GATE1_BIT       = 0;
    localparam int unsigned IPEB_CAPCOMP2_BIT    = 1;
    localparam int unsigned IPEB_CAPCOMP1_BIT    = 0;

endpackage

// *** rtl/ipeb_top.sv ***
`timescale 1ns/1ps
module ipeb_top
    import ipeb_pkg::*;
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ipeb_pkg::IPEB_ADDR_W-1:0] paddr,
    input  wire logic [ipeb_pkg::IPEB_DATA_W-1:0] pwdata,
    output logic      [ipeb_pkg::IPEB_DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [7:0]                  flag_group0,
    input  wire logic [7:0]                  flag_group1,
    input  wire logic [7:0]                  flag_group2,
    input  wire logic [7:0]                  flag_group3,
    input  wire logic [7:0]                  flag_group4,
    input  wire logic [7:0]                  flag_group5,
    input  wire logic [7:0]                  flag_group6,
    input  wire logic [7:0]                  flag_group7,
    input  wire logic [7:0]                  enable_group0,
    input  wire logic [7:0]                  enable_group1,
    input  wire logic [7:0]                  enable_group2,
    input  wire logic [7:0]                  enable_group3,
    input  wire logic [7:0]                  enable_group4,
    input  wire logic [7:0]                  enable_group5,
    input  wire logic [7:0]                  enable_group6,
    input  wire logic                        peripheral_global_en,
    output logic                             irq_high,
    output logic                             irq_low
);
    import ipeb_pkg::*;

    localparam logic [7:0] PRIO_MASK [IPEB_GROUPS] = '{
        IPEB_PRIO_MASK0, IPEB_PRIO_MASK1, IPEB_PRIO_MASK2,
        IPEB_PRIO_MASK3, IPEB_PRIO_MASK4, IPEB_PRIO_MASK5,
        IPEB_PRIO_MASK6, IPEB_PRIO_MASK7};

    logic [7:0]             enable7_q;
    logic [7:0]             prio_q [IPEB_GROUPS];
    logic [IPEB_DATA_W-1:0] prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;
    logic                   irq_high_q;
    logic                   irq_low_q;
    logic [7:0]             flag_w [IPEB_GROUPS];
    logic [7:0]             en_w [IPEB_GROUPS];
    logic                   access_w;
    logic                   commit_w;
    logic                   hit_w;
    logic [IPEB_DATA_W-1:0] rdata_w;
    logic                   high_d;
    logic                   low_d;
    logic [7:0]             enable7_view_w;
    logic [7:0]             prio_view_w [IPEB_GROUPS];

    // named fields, one per implemented register bit
    logic                   memscan_irq_en;
    logic                   checksum_irq_en;
    logic                   nonvolatile_irq_en;
    logic                   waveform_gen_irq_en;
    logic                   timer_zero_prio;
    logic                   pin_change_prio;
    logic                   ext_irq_two_prio;
    logic                   ext_irq_one_prio;
    logic                   ext_irq_zero_prio;
    logic                   osc_fail_prio;
    logic                   clock_switch_prio;
    logic                   converter_threshold_prio;
    logic                   converter_done_prio;
    logic                   voltage_detect_prio;
    logic                   zero_cross_prio;
    logic                   comparator_two_prio;
    logic                   comparator_one_prio;
    logic                   serial_two_rx_prio;
    logic                   serial_two_tx_prio;
    logic                   serial_one_rx_prio;
    logic                   serial_one_tx_prio;
    logic                   sync_two_collision_prio;
    logic                   sync_two_event_prio;
    logic                   sync_one_collision_prio;
    logic                   sync_one_event_prio;
    logic                   timer_six_match_prio;
    logic                   timer_five_ovf_prio;
    logic                   timer_four_match_prio;
    logic                   timer_three_ovf_prio;
    logic                   timer_two_match_prio;
    logic                   timer_one_ovf_prio;
    logic                   timer_five_gate_prio;
    logic                   timer_three_gate_prio;
    logic                   timer_one_gate_prio;
    logic                   capcomp_two_prio;
    logic                   capcomp_one_prio;
    logic                   memscan_prio;
    logic                   checksum_prio;
    logic                   nonvolatile_prio;
    logic                   waveform_gen_prio;

    // byte offset of a priority register from its group number
    function automatic logic [7:0] prio_ofs(input int unsigned g);
        prio_ofs = IPEB_OFS_PRIO0 + 8'(g * 4);
    endfunction

    assign flag_w[0] = flag_group0;
    assign flag_w[1] = flag_group1;
    assign flag_w[2] = flag_group2;
    assign flag_w[3] = flag_group3;
    assign flag_w[4] = flag_group4;
    assign flag_w[5] = flag_group5;
    assign flag_w[6] = flag_group6;
    assign flag_w[7] = flag_group7;
    assign en_w[0]   = enable_group0;
    assign en_w[1]   = enable_group1;
    assign en_w[2]   = enable_group2;
    assign en_w[3]   = enable_group3;
    assign en_w[4]   = enable_group4;
    assign en_w[5]   = enable_group5;
    assign en_w[6]   = enable_group6;
    assign en_w[7]   = enable7_q;

    // field taps; a misplaced field shows up as a readback mismatch
    assign memscan_irq_en = enable7_q[IPEB_MEMSCAN_BIT];
    assign checksum_irq_en = enable7_q[IPEB_CHECKSUM_BIT];
    assign nonvolatile_irq_en = enable7_q[IPEB_NONVOL_BIT];
    assign waveform_gen_irq_en = enable7_q[IPEB_WAVEFORM_BIT];
    assign timer_zero_prio = prio_q[0][IPEB_TIMER_ZERO_BIT];
    assign pin_change_prio = prio_q[0][IPEB_PIN_CHANGE_BIT];
    assign ext_irq_two_prio = prio_q[0][IPEB_EXT_TWO_BIT];
    assign ext_irq_one_prio = prio_q[0][IPEB_EXT_ONE_BIT];
    assign ext_irq_zero_prio = prio_q[0][IPEB_EXT_ZERO_BIT];
    assign osc_fail_prio = prio_q[1][IPEB_OSC_FAIL_BIT];
    assign clock_switch_prio = prio_q[1][IPEB_CLK_SWITCH_BIT];
    assign converter_threshold_prio = prio_q[1][IPEB_CONV_THRESH_BIT];
    assign converter_done_prio = prio_q[1][IPEB_CONV_DONE_BIT];
    assign voltage_detect_prio = prio_q[2][IPEB_VOLT_DETECT_BIT];
    assign zero_cross_prio = prio_q[2][IPEB_ZERO_CROSS_BIT];
    assign comparator_two_prio = prio_q[2][IPEB_COMP_TWO_BIT];
    assign comparator_one_prio = prio_q[2][IPEB_COMP_ONE_BIT];
    assign serial_two_rx_prio = prio_q[3][IPEB_SER2_RX_BIT];
    assign serial_two_tx_prio = prio_q[3][IPEB_SER2_TX_BIT];
    assign serial_one_rx_prio = prio_q[3][IPEB_SER1_RX_BIT];
    assign serial_one_tx_prio = prio_q[3][IPEB_SER1_TX_BIT];
    assign sync_two_collision_prio = prio_q[3][IPEB_SYNC2_COLL_BIT];
    assign sync_two_event_prio = prio_q[3][IPEB_SYNC2_EVT_BIT];
    assign sync_one_collision_prio = prio_q[3][IPEB_SYNC1_COLL_BIT];
    assign sync_one_event_prio = prio_q[3][IPEB_SYNC1_EVT_BIT];
    assign timer_six_match_prio = prio_q[4][IPEB_TIMER6_BIT];
    assign timer_five_ovf_prio = prio_q[4][IPEB_TIMER5_BIT];
    assign timer_four_match_prio = prio_q[4][IPEB_TIMER4_BIT];
    assign timer_three_ovf_prio = prio_q[4][IPEB_TIMER3_BIT];
    assign timer_two_match_prio = prio_q[4][IPEB_TIMER2_BIT];
    assign timer_one_ovf_prio = prio_q[4][IPEB_TIMER1_BIT];
    assign timer_five_gate_prio = prio_q[5][IPEB_GATE5_BIT];
    assign timer_three_gate_prio = prio_q[5][IPEB_GATE3_BIT];
    assign timer_one_gate_prio = prio_q[5][IPEB_GATE1_BIT];
    assign capcomp_two_prio = prio_q[6][IPEB_CAPCOMP2_BIT];
    assign capcomp_one_prio = prio_q[6][IPEB_CAPCOMP1_BIT];
    assign memscan_prio = prio_q[7][IPEB_MEMSCAN_BIT];
    assign checksum_prio = prio_q[7][IPEB_CHECKSUM_BIT];
    assign nonvolatile_prio = prio_q[7][IPEB_NONVOL_BIT];
    assign waveform_gen_prio = prio_q[7][IPEB_WAVEFORM_BIT];

    // read views rebuilt field by field, gaps stay zero
    always_comb begin
        enable7_view_w = 8'h00;
        for (int unsigned g = 0; g < IPEB_GROUPS; g++) begin
            prio_view_w[g] = 8'h00;
        end
        enable7_view_w[IPEB_MEMSCAN_BIT]  = memscan_irq_en;
        enable7_view_w[IPEB_CHECKSUM_BIT] = checksum_irq_en;
        enable7_view_w[IPEB_NONVOL_BIT]   = nonvolatile_irq_en;
        enable7_view_w[IPEB_WAVEFORM_BIT] = waveform_gen_irq_en;
        prio_view_w[0][IPEB_TIMER_ZERO_BIT] = timer_zero_prio;
        prio_view_w[0][IPEB_PIN_CHANGE_BIT] = pin_change_prio;
        prio_view_w[0][IPEB_EXT_TWO_BIT] = ext_irq_two_prio;
        prio_view_w[0][IPEB_EXT_ONE_BIT] = ext_irq_one_prio;
        prio_view_w[0][IPEB_EXT_ZERO_BIT] = ext_irq_zero_prio;
        prio_view_w[1][IPEB_OSC_FAIL_BIT] = osc_fail_prio;
        prio_view_w[1][IPEB_CLK_SWITCH_BIT] = clock_switch_prio;
        prio_view_w[1][IPEB_CONV_THRESH_BIT] = converter_threshold_prio;
        prio_view_w[1][IPEB_CONV_DONE_BIT] = converter_done_prio;
        prio_view_w[2][IPEB_VOLT_DETECT_BIT] = voltage_detect_prio;
        prio_view_w[2][IPEB_ZERO_CROSS_BIT] = zero_cross_prio;
        prio_view_w[2][IPEB_COMP_TWO_BIT] = comparator_two_prio;
        prio_view_w[2][IPEB_COMP_ONE_BIT] = comparator_one_prio;
        prio_view_w[3][IPEB_SER2_RX_BIT] = serial_two_rx_prio;
        prio_view_w[3][IPEB_SER2_TX_BIT] = serial_two_tx_prio;
        prio_view_w[3][IPEB_SER1_RX_BIT] = serial_one_rx_prio;
        prio_view_w[3][IPEB_SER1_TX_BIT] = serial_one_tx_prio;
        prio_view_w[3][IPEB_SYNC2_COLL_BIT] = sync_two_collision_prio;
        prio_view_w[3][IPEB_SYNC2_EVT_BIT] = sync_two_event_prio;
        prio_view_w[3][IPEB_SYNC1_COLL_BIT] = sync_one_collision_prio;
        prio_view_w[3][IPEB_SYNC1_EVT_BIT] = sync_one_event_prio;
        prio_view_w[4][IPEB_TIMER6_BIT] = timer_six_match_prio;
        prio_view_w[4][IPEB_TIMER5_BIT] = timer_five_ovf_prio;
        prio_view_w[4][IPEB_TIMER4_BIT] = timer_four_match_prio;
        prio_view_w[4][IPEB_TIMER3_BIT] = timer_three_ovf_prio;
        prio_view_w[4][IPEB_TIMER2_BIT] = timer_two_match_prio;
        prio_view_w[4][IPEB_TIMER1_BIT] = timer_one_ovf_prio;
        prio_view_w[5][IPEB_GATE5_BIT] = timer_five_gate_prio;
        prio_view_w[5][IPEB_GATE3_BIT] = timer_three_gate_prio;
        prio_view_w[5][IPEB_GATE1_BIT] = timer_one_gate_prio;
        prio_view_w[6][IPEB_CAPCOMP2_BIT] = capcomp_two_prio;
        prio_view_w[6][IPEB_CAPCOMP1_BIT] = capcomp_one_prio;
        prio_view_w[7][IPEB_MEMSCAN_BIT] = memscan_prio;
        prio_view_w[7][IPEB_CHECKSUM_BIT] = checksum_prio;
        prio_view_w[7][IPEB_NONVOL_BIT] = nonvolatile_prio;
        prio_view_w[7][IPEB_WAVEFORM_BIT] = waveform_gen_prio;
    end

    // one wait state so read data and pready both come from flops
    assign access_w = psel && penable;
    assign commit_w = access_w && pready_q;

    // read decode; unmapped addresses answer with pslverr
    always_comb begin
        rdata_w = '0;
        hit_w   = 1'b0;
        if (paddr == IPEB_OFS_ENABLE7) begin
            hit_w   = 1'b1;
            rdata_w = {24'h000000, enable7_view_w};
        end
        if (paddr == IPEB_OFS_STATUS) begin
            hit_w = 1'b1;
            rdata_w[IPEB_STAT_HIGH_BIT] = irq_high_q;
            rdata_w[IPEB_STAT_LOW_BIT]  = irq_low_q;
        end
        for (int unsigned g = 0; g < IPEB_GROUPS; g++) begin
            if (paddr == prio_ofs(g)) begin
                hit_w   = 1'b1;
                rdata_w = {24'h000000, prio_view_w[g]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= access_w && !pready_q;
            pslverr_q <= access_w && !pready_q && !hit_w;
            if (access_w && !pready_q && !pwrite) begin
                prdata_q <= rdata_w;
            end
        end
    end

    // final enable register: only the four documented bits store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable7_q <= IPEB_ENABLE7_RESET;
        end else if (commit_w && pwrite && paddr == IPEB_OFS_ENABLE7) begin
            enable7_q <= pwdata[7:0] & IPEB_ENABLE7_MASK;
        end
    end

    // priority registers; masks place the fields per group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int unsigned g = 0; g < IPEB_GROUPS; g++) begin
                prio_q[g] <= PRIO_MASK[g];
            end
        end else begin
            for (int unsigned g = 0; g < IPEB_GROUPS; g++) begin
                if (commit_w && pwrite && paddr == prio_ofs(g)) begin
                    prio_q[g] <= pwdata[7:0] & PRIO_MASK[g];
                end
            end
        end
    end

    // request routing
    always_comb begin
        high_d = 1'b0;
        low_d  = 1'b0;
        for (int unsigned g = 0; g < IPEB_GROUPS; g++) begin
            // group zero bypasses the peripheral gate
            if (g == 0 || peripheral_global_en) begin
                high_d = high_d |
                    (|(flag_w[g] & en_w[g] & prio_q[g] & PRIO_MASK[g]));
                low_d  = low_d |
                    (|(flag_w[g] & en_w[g] & ~prio_q[g] & PRIO_MASK[g]));
            end
        end
    end

    // one cycle of latency buys flop-driven request lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_high_q <= 1'b0;
            irq_low_q  <= 1'b0;
        end else begin
            irq_high_q <= high_d;
            irq_low_q  <= low_d;
        end
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign irq_high = irq_high_q;
    assign irq_low  = irq_low_q;

endmodule

// *** test/ipeb_src.sv ***
`timescale 1ns/1ps
// peripheral side: one flagged source at a time, held as a level
module ipeb_src (
    input  wire logic        pclk,
    input  wire logic [5:0]  src,
    input  wire logic        set,
    output logic      [63:0] flags
);
    always_ff @(posedge pclk) flags <= set ? 64'h1 << src : '0;
endmodule

// *** test/ipeb_monitor.sv ***
`timescale 1ns/1ps
module ipeb_monitor
    import ipeb_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  flag_group0,
    input wire logic [7:0]  enable_group0,
    input wire logic        peripheral_global_en,
    input wire logic        irq_high,
    input wire logic        irq_low
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("late ready");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("stray ready");
    a_err_unmapped: assert property
        (pready && paddr > 8'h24 |-> pslverr)
        else $error("no error");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("stray error");
    a_read_upper: assert property
        (pready && !pwrite |-> prdata[31:8] == 0)
        else $error("upper bits set");
    a_irq_cause: assert property (irq_high || irq_low |->
        $past(|(flag_group0 & enable_group0) || peripheral_global_en))
        else $error("request without cause");
    a_status_copy: assert property
        (pready && !pwrite && paddr == 8'h24 |->
        prdata[1:0] == {$past(irq_low), $past(irq_high)})
        else $error("status mismatch");
    c_err: cover property (pslverr);
    c_high: cover property (irq_high);
    c_low: cover property (irq_low && !peripheral_global_en);
endmodule
bind ipeb_top ipeb_monitor u_ipeb_monitor (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .flag_group0, .enable_group0,
    .peripheral_global_en, .irq_high, .irq_low);

// *** test/interrupt_priority_enable_bank_tb.sv ***
`timescale 1ns/1ps
module interrupt_priority_enable_bank_tb;
    import ipeb_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        gen = 0, set = 0, pready, pslverr, irq_high, irq_low, er;
    logic [7:0]  paddr = 0, en = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [5:0]  src = 0;
    logic [63:0] flags;
    int          bad_count = 0, num_checks = 0, n;
    // index 0 is the final enable register, then priority groups 0..7
    logic [7:0]  m [9] = '{8'hE1, 8'h37, 8'hC3, 8'hC3, 8'hFF, 8'h3F, 8'h07,
                           8'h03, 8'hE1};
    always #2.5 pclk = ~pclk;
    ipeb_src u_ipeb_src (.pclk, .src, .set, .flags);
    ipeb_top u_ipeb_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq_high, .irq_low,
        .flag_group0(flags[7:0]), .flag_group1(flags[15:8]),
        .flag_group2(flags[23:16]), .flag_group3(flags[31:24]),
        .flag_group4(flags[39:32]), .flag_group5(flags[47:40]),
        .flag_group6(flags[55:48]), .flag_group7(flags[63:56]),
        .enable_group0(en), .enable_group1(en), .enable_group2(en),
        .enable_group3(en), .enable_group4(en), .enable_group5(en),
        .enable_group6(en), .peripheral_global_en(gen));
    task complete_run();
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // waits on pready with a bound; a hang ends the run
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 20) begin
            bad_count++;
            complete_run();
        end
    endtask
    task rst();
        presetn <= 0;
        repeat (4) @(posedge pclk);
        presetn <= 1;
    endtask
    // partner adds one edge before the flag reaches the block
    task ic(input logic h, input logic l);
        repeat (3) @(posedge pclk);
        chk(32'({irq_high, irq_low}), 32'({h, l}));
    endtask
    initial begin
        rst();
        for (int g = 0; g < 9; g++) begin
            xfer(0, 8'(4 * g), 0);
            chk(rd, g ? 32'(m[g]) : 0);
            xfer(1, 8'(4 * g), 32'hFFFF_FFFF);
            xfer(0, 8'(4 * g), 0);
            chk(rd, 32'(m[g]));
            chk(rd[31:8], 0);
            xfer(1, 8'(4 * g), 32'hFFFF_FF00);
            xfer(0, 8'(4 * g), 0);
            chk(rd, 0);
        end
        xfer(1, 8'h00, 32'h0000_00E1);
        en <= 8'hFF;
        gen <= 1;
        set <= 1;
        src <= 6'd56;
        ic(0, 1);
        xfer(1, 8'h20, 32'h0000_0001);
        ic(1, 0);
        xfer(0, 8'h24, 0);
        chk(rd, 32'h1);
        chk(32'(er), 0);
        xfer(1, 8'h00, 0);
        ic(0, 0);
        gen <= 0;
        src <= 6'd0;
        ic(0, 1);
        xfer(0, 8'h24, 0);
        chk(rd, 32'h2);
        src <= 6'd8;
        ic(0, 0);
        xfer(1, 8'h28, 32'hFF);
        chk(32'(er), 1);
        xfer(0, 8'h28, 0);
        chk(rd, 0);
        xfer(1, 8'h00, 32'h0000_00E1);
        rst();
        xfer(0, 8'h04, 0);
        chk(rd, 32'h37);
        xfer(0, 8'h00, 0);
        chk(rd, 0);
        complete_run();
    end
endmodule
